/* File: rtl/asc_sequencer_ctrl.sv */
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module asc_sequencer_ctrl
   import asc_pkg::*;
#(
   parameter int NUM_PERIPH_TRIG = 14
) (
   input  wire logic                   clk,
   input  wire logic                   rstn,
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic                        hreadyout,
   output logic                        hresp,
   output logic [31:0]                 hrdata,
   input  wire logic [NUM_PERIPH_TRIG-1:0] periphTrig,
   output asc_conv_req_t               convReq,
   input  wire logic                   convDone,
   input  wire logic [RESULT_BITS-1:0] convResult,
   output logic [NUM_SEQ-1:0]          seqIrq
);
   // codes 1..14 of the select field name peripheral sources, so more cannot be reached
   if (NUM_PERIPH_TRIG < 1 || NUM_PERIPH_TRIG > 14) begin : g_chk
      $error("NUM_PERIPH_TRIG must lie in 1..14");
   end

   typedef struct packed {
      asc_fsm_t                              fsm;
      logic [1:0]                            cur;
      logic [2:0]                            step;
      logic [6:0]                            avgCnt;
      logic [15:0]                           acc;
      logic [3:0]                            tickCnt;
      logic [NUM_SEQ-1:0]                    en;
      logic [NUM_SEQ-1:0]                    raw;
      logic [NUM_SEQ-1:0]                    mask;
      logic [NUM_SEQ-1:0]                    ostat;
      logic [NUM_SEQ-1:0]                    ustat;
      logic [NUM_SEQ-1:0]                    pend;
      logic [15:0]                           emux;
      logic [15:0]                           pri;
      logic [2:0]                            sac;
      logic [NUM_SEQ-1:0][31:0]              mux;
      logic [NUM_SEQ-1:0][31:0]              ctl;
      logic [NUM_SEQ-1:0][MAX_DEPTH-1:0][RESULT_BITS-1:0] mem;
      logic [NUM_SEQ-1:0][2:0]               head;
      logic [NUM_SEQ-1:0][2:0]               tail;
      logic [NUM_SEQ-1:0][3:0]               cnt;
      logic [NUM_PERIPH_TRIG-1:0]            trigPrev;
      logic                                  wrPend;
      logic [7:0]                            wrAddr;
      logic                                  rdWait;
      logic [7:0]                            rdAddr;
      logic [31:0]                           rdata;
      asc_conv_req_t                         conv;
   } asc_regs_t;

   asc_regs_t                  r_reg;
   asc_regs_t                  r_next;
   logic                       tick;
   logic                       pushEv;
   logic [RESULT_BITS-1:0]     pushData;
   logic                       ieBit;
   logic                       lastStep;
   logic                       rdIsFifo;
   logic                       prioOk;
   logic [NUM_SEQ-1:0]         setRaw;

   assign hreadyout = ~r_reg.rdWait;
   assign hresp     = 1'b0;
   assign hrdata    = r_reg.rdata;
   assign convReq   = r_reg.conv;
   assign seqIrq    = r_reg.raw & r_reg.mask; // [RULE10]

   always_comb begin
      logic               addrPhase;
      logic [NUM_SEQ-1:0] clrRaw;
      logic [NUM_SEQ-1:0] clrO;
      logic [NUM_SEQ-1:0] clrU;
      logic [NUM_SEQ-1:0] setO;
      logic [NUM_SEQ-1:0] setU;
      logic [NUM_SEQ-1:0] pop;
      logic [NUM_SEQ-1:0] trig;
      logic               found;
      logic [1:0]         best;
      logic [1:0]         bestPri;
      logic [3:0]         sel;
      logic [3:0]         inNib;
      logic [3:0]         ctlNib;
      logic [15:0]        sum;
      logic [31:0]        rdVal;
      logic [7:0]         seqA;
      logic               pssiWr;
      r_next   = r_reg;
      addrPhase = 1'b0;
      clrRaw   = '0;
      clrO     = '0;
      clrU     = '0;
      setO     = '0;
      setU     = '0;
      setRaw   = '0;
      pop      = '0;
      trig     = '0;
      found    = 1'b0;
      best     = 2'd0;
      bestPri  = 2'd3;
      sel      = 4'h0;
      sum      = 16'h0000;
      rdVal    = 32'h00000000;
      seqA     = 8'h00;
      pushEv   = 1'b0;
      pushData = '0;
      ieBit    = 1'b0;
      lastStep = 1'b0;
      rdIsFifo = 1'b0;
      prioOk   = 1'b1;
      r_next.conv.start = 1'b0;

      // converter pacing clock, one tick per converter period
      tick = (r_reg.tickCnt == 4'(CONV_DIV - 1)); // [RULE9]
      r_next.tickCnt = tick ? 4'h0 : r_reg.tickCnt + 4'h1;

      // bus: zero-wait writes, one-wait reads so a read sees the write before it
      addrPhase = hsel && htrans[1] && hready && (hsize == 3'b010);
      r_next.wrPend = addrPhase && hwrite;
      r_next.rdWait = addrPhase && !hwrite;
      r_next.wrAddr = haddr[7:0];
      r_next.rdAddr = haddr[7:0];
      pssiWr = r_reg.wrPend && (r_reg.wrAddr == OFF_PSSI);
      if (r_reg.wrPend) begin
         case (r_reg.wrAddr)
            OFF_ENABLE: r_next.en = hwdata[NUM_SEQ-1:0];
            OFF_MASK:   r_next.mask = hwdata[NUM_SEQ-1:0];
            OFF_ISC:    clrRaw = hwdata[NUM_SEQ-1:0]; // [RULE11]
            OFF_OSTAT:  clrO = hwdata[NUM_SEQ-1:0]; // [RULE23]
            OFF_USTAT:  clrU = hwdata[NUM_SEQ-1:0]; // [RULE23]
            OFF_EMUX:   r_next.emux = hwdata[15:0]; // [RULE14]
            OFF_PRI:    r_next.pri = hwdata[15:0] & PRI_MASK;
            OFF_SAC:    r_next.sac = (hwdata[2:0] > AVG_MAX_LOG) ? AVG_MAX_LOG : hwdata[2:0];
            default: begin
            end
         endcase
         for (int i = 0; i < NUM_SEQ; i++) begin
            seqA = 8'(SEQ_BASE + i * SEQ_STRIDE);
            // unused step nibbles of the short sequencers stay zero
            if (r_reg.wrAddr == seqA + 8'(OFS_MUX)) begin
               r_next.mux[i] = hwdata & 32'((64'h1 << (4 * SEQ_DEPTH[i])) - 64'h1); // [RULE3]
            end
            if (r_reg.wrAddr == seqA + 8'(OFS_CTL)) begin
               r_next.ctl[i] = hwdata & 32'((64'h1 << (4 * SEQ_DEPTH[i])) - 64'h1); // [RULE3]
            end
         end
      end

      // register read, taken in the wait cycle
      if (r_reg.rdWait) begin
         case (r_reg.rdAddr)
            OFF_ENABLE: rdVal = 32'(r_reg.en);
            OFF_RAW:    rdVal = 32'(r_reg.raw); // [RULE10]
            OFF_MASK:   rdVal = 32'(r_reg.mask);
            OFF_ISC:    rdVal = 32'(r_reg.raw & r_reg.mask); // [RULE10]
            OFF_OSTAT:  rdVal = 32'(r_reg.ostat); // [RULE8]
            OFF_USTAT:  rdVal = 32'(r_reg.ustat); // [RULE8]
            OFF_EMUX:   rdVal = 32'(r_reg.emux);
            OFF_PRI:    rdVal = 32'(r_reg.pri);
            OFF_SAC:    rdVal = 32'(r_reg.sac);
            default:    rdVal = 32'h00000000;
         endcase
         for (int i = 0; i < NUM_SEQ; i++) begin
            seqA = 8'(SEQ_BASE + i * SEQ_STRIDE);
            if (r_reg.rdAddr == seqA + 8'(OFS_MUX)) begin
               rdVal = r_reg.mux[i];
            end
            if (r_reg.rdAddr == seqA + 8'(OFS_CTL)) begin
               rdVal = r_reg.ctl[i];
            end
            if (r_reg.rdAddr == seqA + 8'(OFS_FIFO)) begin
               rdIsFifo = 1'b1;
               pop[i] = 1'b1; // [RULE7]
               // an empty pop returns zero
               rdVal = (r_reg.cnt[i] == 4'h0) ? 32'h00000000 : 32'(r_reg.mem[i][r_reg.head[i]]); // [RULE2]
            end
            if (r_reg.rdAddr == seqA + 8'(OFS_FSTAT)) begin
               rdVal = 32'h00000000;
               rdVal[FSTAT_TAIL_POS +: 3] = r_reg.tail[i]; // [RULE8]
               rdVal[FSTAT_HEAD_POS +: 3] = r_reg.head[i];
               rdVal[FSTAT_EMPTY_POS] = (r_reg.cnt[i] == 4'h0);
               rdVal[FSTAT_FULL_POS] = (r_reg.cnt[i] == 4'(SEQ_DEPTH[i]));
            end
         end
         r_next.rdata = rdVal;
      end

      // sequencer engine
      inNib  = r_reg.mux[r_reg.cur][{r_reg.step, 2'b00} +: 4];
      ctlNib = r_reg.ctl[r_reg.cur][{r_reg.step, 2'b00} +: 4];
      sum    = r_reg.acc + 16'(convResult);
      case (r_reg.fsm)
         ST_IDLE: begin
            for (int i = 0; i < NUM_SEQ; i++) begin
               // strict compare: equal priorities fall to the lower index
               if (r_reg.pend[i] && r_reg.en[i] && (!found || r_reg.pri[i*4 +: 2] < bestPri)) begin // [RULE12] [RULE13]
                  found   = 1'b1;
                  best    = 2'(i);
                  bestPri = r_reg.pri[i*4 +: 2];
               end
            end
            for (int i = 0; i < NUM_SEQ; i++) begin
               if (found && r_reg.pend[i] && r_reg.en[i] && r_reg.pri[i*4 +: 2] < bestPri) begin
                  prioOk = 1'b0;
               end
            end
            if (found) begin
               r_next.cur    = best;
               r_next.step   = 3'd0;
               r_next.avgCnt = 7'd0;
               r_next.acc    = 16'h0000;
               r_next.fsm    = ST_ARM;
            end
         end
         ST_ARM: begin
            if (!r_reg.en[r_reg.cur]) begin
               r_next.fsm = ST_IDLE; // [RULE4]
            end else if (tick) begin
               r_next.conv.start   = 1'b1; // [RULE9]
               r_next.conv.diff    = ctlNib[CTL_DIFF];
               r_next.conv.temp    = ctlNib[CTL_TEMP];
               // differential pair k drives even input 2k positive, 2k+1 negative
               r_next.conv.channel = ctlNib[CTL_DIFF] ? {inNib[2:0], 1'b0} : inNib; // [RULE20] [RULE21]
               r_next.fsm          = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (convDone) begin
               // one shared accumulator; the factor applies to every step alike
               if (r_reg.avgCnt == 7'((7'h1 << r_reg.sac) - 7'h1)) begin // [RULE17] [RULE18]
                  pushEv   = 1'b1;
                  pushData = RESULT_BITS'(sum >> r_reg.sac); // [RULE19] [RULE21]
                  ieBit    = ctlNib[CTL_IE];
                  lastStep = ctlNib[CTL_END] || (r_reg.step == 3'(SEQ_DEPTH[r_reg.cur] - 1));
                  if (ieBit) begin
                     setRaw[r_reg.cur] = 1'b1; // [RULE5]
                  end
                  r_next.acc    = 16'h0000;
                  r_next.avgCnt = 7'd0;
                  if (lastStep) begin
                     r_next.pend[r_reg.cur] = 1'b0; // [RULE6]
                     r_next.fsm = ST_IDLE;
                  end else begin
                     r_next.step = r_reg.step + 3'd1;
                     r_next.fsm  = ST_ARM;
                  end
               end else begin
                  r_next.acc    = sum; // [RULE17]
                  r_next.avgCnt = r_reg.avgCnt + 7'd1;
                  r_next.fsm    = ST_ARM;
               end
            end
         end
         default: r_next.fsm = ST_IDLE;
      endcase
      // result fifos; a push into a full fifo is dropped even if a pop lands in the same cycle
      for (int i = 0; i < NUM_SEQ; i++) begin
         logic doPush;
         logic doPop;
         doPush = pushEv && (r_reg.cur == 2'(i)) && (r_reg.cnt[i] != 4'(SEQ_DEPTH[i]));
         doPop  = pop[i] && (r_reg.cnt[i] != 4'h0);
         setO[i] = pushEv && (r_reg.cur == 2'(i)) && (r_reg.cnt[i] == 4'(SEQ_DEPTH[i])); // [RULE23]
         setU[i] = pop[i] && (r_reg.cnt[i] == 4'h0); // [RULE23]
         if (doPush) begin
            r_next.mem[i][r_reg.tail[i]] = pushData; // [RULE1]
            r_next.tail[i] = (r_reg.tail[i] == 3'(SEQ_DEPTH[i] - 1)) ? 3'd0 : r_reg.tail[i] + 3'd1; // [RULE7]
         end
         if (doPop) begin
            r_next.head[i] = (r_reg.head[i] == 3'(SEQ_DEPTH[i] - 1)) ? 3'd0 : r_reg.head[i] + 3'd1; // [RULE7]
         end
         r_next.cnt[i] = r_reg.cnt[i] + 4'(doPush) - 4'(doPop);
      end

      // sticky flags: a set in the clearing cycle survives
      r_next.raw   = (r_reg.raw & ~clrRaw) | setRaw; // [RULE11]
      r_next.ostat = (r_reg.ostat & ~clrO) | setO; // [RULE8]
      r_next.ustat = (r_reg.ustat & ~clrU) | setU; // [RULE8]

      // triggers; placed after the engine so a new trigger wins over completion
      for (int i = 0; i < NUM_SEQ; i++) begin
         sel = r_reg.emux[i*4 +: 4];
         if (sel == TRIG_ALWAYS) begin
            trig[i] = 1'b1; // [RULE14]
         end else if (sel == TRIG_SOFTWARE) begin
            trig[i] = pssiWr && hwdata[i]; // [RULE15]
         end else if (int'(sel) <= NUM_PERIPH_TRIG) begin
            trig[i] = periphTrig[int'(sel) - 1] && !r_reg.trigPrev[int'(sel) - 1]; // [RULE14]
         end
         if (!r_next.en[i]) begin
            r_next.pend[i] = 1'b0; // [RULE4]
         end else if (trig[i]) begin
            r_next.pend[i] = 1'b1;
         end
      end
      r_next.trigPrev = periphTrig;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         r_reg        <= '0; // [RULE18]
         r_reg.pri    <= PRI_RST; // [RULE22]
         r_reg.ctl[3] <= CTL3_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_startOnTick;
      r_reg.conv.start |-> r_reg.tickCnt == 4'h0;
   endproperty
   a_startOnTick: assert property (p_startOnTick) else $error("conversion start off the converter tick"); // [RULE9]

   property p_fifoBound;
      r_reg.cnt[0] <= 4'd8 && r_reg.cnt[1] <= 4'd4 && r_reg.cnt[2] <= 4'd4 && r_reg.cnt[3] <= 4'd1;
   endproperty
   a_fifoBound: assert property (p_fifoBound) else $error("fifo count beyond its depth"); // [RULE1]

   property p_readWidth;
      (r_reg.rdWait && rdIsFifo) |=> hrdata[31:10] == 22'h000000;
   endproperty
   a_readWidth: assert property (p_readWidth) else $error("fifo word has bits above the result"); // [RULE2]

   property p_enabledRun;
      r_reg.conv.start |-> $past(r_reg.en[r_reg.cur]);
   endproperty
   a_enabledRun: assert property (p_enabledRun) else $error("conversion on a disabled sequencer"); // [RULE4]

   property p_irqRaise;
      (pushEv && ieBit) |=> r_reg.raw[$past(r_reg.cur)];
   endproperty
   a_irqRaise: assert property (p_irqRaise) else $error("raw interrupt not raised"); // [RULE5]

   property p_endStop;
      (pushEv && lastStep) |=> r_reg.fsm == ST_IDLE ##1 !r_reg.conv.start;
   endproperty
   a_endStop: assert property (p_endStop) else $error("sequence ran past its end step"); // [RULE6]

   property p_maskedView;
      (r_reg.rdWait && r_reg.rdAddr == OFF_ISC) |=> hrdata[3:0] == $past(r_reg.raw & r_reg.mask);
   endproperty
   a_maskedView: assert property (p_maskedView) else $error("masked status view wrong"); // [RULE10]

   property p_w1c;
      (r_reg.wrPend && r_reg.wrAddr == OFF_ISC && hwdata[0] && !setRaw[0]) |=> !r_reg.raw[0];
   endproperty
   a_w1c: assert property (p_w1c) else $error("interrupt not cleared by write of one"); // [RULE11]

   property p_prio;
      r_reg.fsm == ST_IDLE |-> prioOk;
   endproperty
   a_prio: assert property (p_prio) else $error("lower priority sequencer granted first"); // [RULE12]

   property p_overflow;
      (pushEv && r_reg.cnt[r_reg.cur] == 4'(SEQ_DEPTH[r_reg.cur])) |=> r_reg.ostat[$past(r_reg.cur)];
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow flag not set"); // [RULE23]

   c_seqEnd:  cover property (pushEv && lastStep && r_reg.step != 3'd0);
   c_fifoPop: cover property (r_reg.rdWait && rdIsFifo);
   c_average: cover property (pushEv && r_reg.sac != 3'd0);
   c_over:    cover property (pushEv && r_reg.cnt[r_reg.cur] == 4'(SEQ_DEPTH[r_reg.cur]));
endmodule // asc_sequencer_ctrl
`default_nettype wire

/* File: rtl/asc_pkg.sv */
// Contract
// [RULE1] four sequencers: seq3 one step/entry, seq1-2 four, seq0 eight
// [RULE2] every result word is 32 bits with the result in bits 9:0
// [RULE3] each step has a 4-bit input nibble and a 4-bit control nibble
// [RULE4] a sequencer runs only while enabled; software configures it first
// [RULE5] a step with its interrupt enable set raises the raw interrupt
// [RULE6] the sequence stops after the step whose end bit is set
// [RULE7] result fifo is circular; each data read pops the oldest entry
// [RULE8] head, tail, full, empty visible; overflow and underflow recorded
// [RULE9] control paced by a converter clock derived near 16.667 MHz
// [RULE10] mask gates interrupt out; raw and masked status views readable
// [RULE11] writing one to a status-and-clear bit clears it; zero does nothing
// [RULE12] concurrent triggers served by priority value, 0 first
// [RULE13] software gives every enabled sequencer a distinct priority
// [RULE14] per-sequencer trigger select: software, always, peripheral sources
// [RULE15] writing one to an initiate bit starts a software-triggered sequencer
// [RULE16] software avoids high priority for always-triggered sequencers
// [RULE17] averaging accumulates up to 64 conversions into one entry
// [RULE18] averaging off after reset; one shared factor for all channels
// [RULE19] single-ended codes run 0x000 to 0x3ff, passed unchanged
// [RULE20] differential step reads nibble as pair k, inputs 2k and 2k+1
// [RULE21] differential: even input positive, zero difference gives 0x1ff
// [RULE22] after reset sequencer 0 has top priority, sequencer 3 lowest
// [RULE23] push into full sets overflow, pop of empty sets underflow, w1c
package asc_pkg;
   localparam int NUM_SEQ      = 4;
   localparam int MAX_DEPTH    = 8;
   localparam int SEQ_DEPTH [NUM_SEQ] = '{8, 4, 4, 1};
   localparam int RESULT_BITS  = 10;

   localparam logic [7:0] OFF_ENABLE = 8'h00;
   localparam logic [7:0] OFF_RAW    = 8'h04;
   localparam logic [7:0] OFF_MASK   = 8'h08;
   localparam logic [7:0] OFF_ISC    = 8'h0c;
   localparam logic [7:0] OFF_OSTAT  = 8'h10;
   localparam logic [7:0] OFF_EMUX   = 8'h14;
   localparam logic [7:0] OFF_USTAT  = 8'h18;
   localparam logic [7:0] OFF_PRI    = 8'h20;
   localparam logic [7:0] OFF_PSSI   = 8'h28;
   localparam logic [7:0] OFF_SAC    = 8'h30;
   localparam int SEQ_BASE   = 'h40;
   localparam int SEQ_STRIDE = 'h20;
   localparam int OFS_MUX    = 'h0;
   localparam int OFS_CTL    = 'h4;
   localparam int OFS_FIFO   = 'h8;
   localparam int OFS_FSTAT  = 'hc;

   localparam logic [15:0] PRI_RST    = 16'h3210;
   localparam logic [15:0] PRI_MASK   = 16'h3333;
   localparam logic [31:0] CTL3_RST   = 32'h00000002;
   localparam int FSTAT_TAIL_POS  = 0;
   localparam int FSTAT_HEAD_POS  = 4;
   localparam int FSTAT_EMPTY_POS = 8;
   localparam int FSTAT_FULL_POS  = 12;

   localparam int CTL_DIFF = 0;
   localparam int CTL_END  = 1;
   localparam int CTL_IE   = 2;
   localparam int CTL_TEMP = 3;

   localparam logic [3:0] TRIG_SOFTWARE = 4'h0;
   localparam logic [3:0] TRIG_ALWAYS   = 4'hf;
   localparam logic [2:0] AVG_MAX_LOG   = 3'h6;

   localparam int CLK_FREQ_KHZ    = 250000;
   localparam int CONV_TARGET_KHZ = 16667;
   localparam int CONV_DIV        = (CLK_FREQ_KHZ + CONV_TARGET_KHZ - 1) / CONV_TARGET_KHZ;

   typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_WAIT} asc_fsm_t;

   typedef struct packed {
      logic       start;
      logic [3:0] channel;
      logic       diff;
      logic       temp;
   } asc_conv_req_t;
endpackage

/* File: test/asc_conv_model.sv */
`timescale 1ns/100ps
`default_nettype none
module asc_conv_model
   import asc_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rstn,
   input  wire asc_conv_req_t          convReq,
   input  wire logic [4:0]             lat,
   output logic                        convDone,
   output logic [RESULT_BITS-1:0]      convResult
);
   logic [5:0] cnt;
   logic [9:0] seed;
   always @(posedge clk) begin
      convDone <= 1'b0;
      // outside the done cycle the result bus churns so stale values never look valid
      convResult <= ~convResult;
      if (!rstn) begin
         cnt <= 6'h00;
         seed <= 10'h155;
         convResult <= 10'h000;
      end else if (convReq.start) begin
         cnt <= {1'b0, lat} + 6'h01;
      end else if (cnt == 6'h01) begin
         convDone <= 1'b1;
         convResult <= {convReq.channel, 6'h00} ^ seed;
         seed <= {seed[8:0], seed[9] ^ seed[6]};
         cnt <= 6'h00;
      end else if (cnt != 6'h00) begin
         cnt <= cnt - 6'h01;
      end
   end
endmodule // asc_conv_model
`default_nettype wire

/* File: test/tb_adc_sample_sequencer_control.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
   $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_adc_sample_sequencer_control
   import asc_pkg::*;
;
   logic          clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0]   haddr = 32'h0, hwdata = 32'h0, hrdata, m;
   logic [1:0]    htrans = 2'h0;
   logic [13:0]   periphTrig = 14'h0;
   logic          hreadyout, hresp, convDone;
   asc_conv_req_t convReq;
   logic [9:0]    convResult;
   logic [3:0]    seqIrq, v;
   logic [4:0]    lat = 5'h00;
   logic [31:0]   rng = 32'h0000ba24;
   int            fails = 0, comparisons = 0, cycles = 0, k;
   logic [9:0]    resQ[$];
   logic [3:0]    chQ[$];
   logic [1:0]    mdQ[$];
   asc_sequencer_ctrl i_dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .periphTrig(periphTrig), .convReq(convReq), .convDone(convDone),
      .convResult(convResult), .seqIrq(seqIrq));
   asc_conv_model i_core (.clk(clk), .rstn(rstn), .convReq(convReq), .lat(lat), .convDone(convDone),
      .convResult(convResult));
   always #2 clk = ~clk;
   always @(posedge clk) begin
      if (convDone) resQ.push_back(convResult);
      if (convReq.start) begin
         chQ.push_back(convReq.channel);
         mdQ.push_back({convReq.temp, convReq.diff});
      end
      cycles++;
      if (cycles == 30000) begin
         fails++;
         test_done();
      end
   end
   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   function automatic logic [7:0] sb(input int n, input int o);
      return 8'(SEQ_BASE + SEQ_STRIDE * n + o);
   endfunction
   function automatic logic [31:0] avgExp(input int sh);
      logic [15:0] s = 16'h0;
      for (int i = 0; i < (1 << sh); i++) s += 16'(resQ[i]);
      return {22'h0, 10'(s >> sh)};
   endfunction
   // called right after a rising edge; hsel stays up, idle cycles are htrans IDLE
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      `CHK(r, e);
   endtask
   task automatic waitConv(input int n);
      lat <= 5'(xs());
      while (resQ.size() < n) @(posedge clk);
      repeat (4) @(posedge clk);
   endtask
   task automatic clr();
      resQ.delete();
      chQ.delete();
      mdQ.delete();
   endtask
   task test_done();
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rdc(OFF_PRI, 32'h3210);
      rdc(sb(3, OFS_CTL), CTL3_RST);
      rdc(sb(0, OFS_FSTAT), 32'h100);
      rdc(OFF_SAC, 32'h0);
      rdc(8'hfc, 32'h0);
      // a trigger while disabled must not start anything
      wr(OFF_PSSI, 32'h1);
      repeat (60) @(posedge clk);
      `CHK(chQ.size(), 0);
      m = xs();
      wr(sb(0, OFS_MUX), m);
      // step 0 selects the temperature sensor, step 1 interrupts, step 2 ends
      wr(sb(0, OFS_CTL), 32'h248);
      wr(OFF_ENABLE, 32'h1);
      wr(OFF_PSSI, 32'h1);
      waitConv(3);
      `CHK(chQ.size(), 3);
      `CHK(mdQ[0], 2'b10);
      rdc(sb(0, OFS_FSTAT), 32'h3);
      for (int i = 0; i < 3; i++) begin
         `CHK(chQ[i], m[4*i+:4]);
         rdc(sb(0, OFS_FIFO), {22'h0, resQ[i]});
      end
      rdc(sb(0, OFS_FIFO), 32'h0);
      rdc(OFF_USTAT, 32'h1);
      wr(OFF_USTAT, 32'h1);
      rdc(OFF_USTAT, 32'h0);
      rdc(OFF_RAW, 32'h1);
      rdc(OFF_ISC, 32'h0);
      `CHK(seqIrq, 4'h0);
      wr(OFF_MASK, 32'h1);
      rdc(OFF_ISC, 32'h1);
      `CHK(seqIrq, 4'h1);
      wr(OFF_ISC, 32'h0);
      rdc(OFF_RAW, 32'h1);
      wr(OFF_ISC, 32'h1);
      rdc(OFF_RAW, 32'h0);
      wr(OFF_ENABLE, 32'h0);
      clr();
      v = 4'(xs() % 3);
      k = xs() % 4;
      wr(sb(3, OFS_MUX), {28'h0, v});
      wr(sb(3, OFS_CTL), 32'h3);
      wr(OFF_SAC, 32'(k));
      wr(OFF_ENABLE, 32'h8);
      wr(OFF_PSSI, 32'h8);
      waitConv(1 << k);
      `CHK(chQ[0], 4'(2 * v));
      `CHK(mdQ[0], 2'b01);
      `CHK(chQ.size(), 1 << k);
      rdc(sb(3, OFS_FIFO), avgExp(k));
      wr(OFF_SAC, 32'h0);
      for (int i = 0; i < 2; i++) begin
         clr();
         wr(OFF_PSSI, 32'h8);
         waitConv(1);
      end
      rdc(sb(3, OFS_FSTAT), 32'h1000);
      rdc(OFF_OSTAT, 32'h8);
      wr(OFF_OSTAT, 32'h8);
      rdc(OFF_OSTAT, 32'h0);
      clr();
      wr(sb(1, OFS_MUX), 32'h1);
      wr(sb(1, OFS_CTL), 32'h2);
      wr(sb(2, OFS_MUX), 32'h2);
      wr(sb(2, OFS_CTL), 32'h2);
      wr(OFF_PRI, 32'h3012);
      wr(OFF_ENABLE, 32'h6);
      wr(OFF_PSSI, 32'h6);
      waitConv(2);
      `CHK(chQ[0], 4'h2);
      `CHK(chQ[1], 4'h1);
      clr();
      // v keeps the pair of sequencer 3 for the always-trigger check below
      k = 1 + xs() % 14;
      wr(OFF_EMUX, {24'h0, 4'(k), 4'h0});
      periphTrig <= 14'(1) << (k - 1);
      waitConv(1);
      periphTrig <= 14'h0;
      `CHK(chQ[0], 4'h1);
      // always trigger kept on the lowest priority so it cannot starve the others
      wr(OFF_EMUX, 32'hf000);
      wr(OFF_ENABLE, 32'h8);
      clr();
      waitConv(2);
      `CHK(chQ[0], 4'(2 * v));
      wr(OFF_ENABLE, 32'h0);
      repeat (60) @(posedge clk);
      clr();
      repeat (60) @(posedge clk);
      `CHK(chQ.size(), 0);
      test_done();
   end
endmodule // tb_adc_sample_sequencer_control
`default_nettype wire
